// file: bench/driver_supervisor_properties.sv
// port assertions of the driver supervisor
module driver_supervisor_properties (
	input wire clk,
	input wire rst,
	input wire [3:0] address,
	input wire read,
	input wire write,
	input wire [31:0] readdata,
	input wire waitrequest,
	input wire system_clear_n,
	input wire sleep_n,
	input wire buck_a_disable,
	input wire motorOcp,
	input wire [2:0] buckEn,
	input wire pumpEn,
	input wire reset_out_n,
	input wire [2:0] plusHigh,
	input wire [2:0] plusLow,
	input wire [2:0] minusHigh,
	input wire [2:0] minusLow
);
	timeunit 1ns;
	timeprecision 1ps;
	wire [2:0] sw = plusHigh | plusLow | minusHigh | minusLow;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus request not answered");
	a_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low too long");
	a_unmapped_zero: assert property (read && waitrequest && address[1:0] != 2'h0
		|=> readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_bridge_diag: assert property (plusHigh == minusLow && plusLow == minusHigh
		&& (plusHigh & plusLow) == 3'h0)
		else $error("bridge switches off diagonal");
	a_bridge_sleep: assert property (!sleep_n [*6] |-> sw == 3'h0)
		else $error("bridge on during sleep");
	a_bridge_fault: assert property (motorOcp [*6] |-> sw == 3'h0)
		else $error("bridge on during motor fault");
	a_clear_off: assert property (!system_clear_n [*8] |->
		buckEn == 3'h0 && !pumpEn && !reset_out_n)
		else $error("clear did not stop supplies");
	a_pump_conv: assert property (buckEn != 3'h0 |-> pumpEn)
		else $error("converter on without pump");
	a_pump_sleep: assert property (reset_out_n && buckEn == 3'h0 && !sleep_n [*6]
		|-> !pumpEn)
		else $error("pump running in sleep");
	a_buck_a_pin: assert property (buck_a_disable [*6] |-> !buckEn[0])
		else $error("converter a on while disabled");
endmodule
bind driver_supervisor driver_supervisor_properties i_props (.clk, .rst, .address, .read,
	.write, .readdata, .waitrequest, .system_clear_n, .sleep_n, .buck_a_disable, .motorOcp,
	.buckEn, .pumpEn, .reset_out_n, .plusHigh, .plusLow, .minusHigh, .minusLow);

// file: bench/driver_supervisor_tb.sv
// self-checking bench of the driver supervisor
module driver_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PUMP = 20, STEP = 20, PULSE = 10, PORT = 200;
	// arbitrary identity values
	localparam logic [2:0] REV = 3'h3;
	localparam logic [1:0] DEV = 2'h1;
	logic clk, rst, clkEn, read, write, supplyLow, system_clear_n, sleep_n, wake_request_n;
	logic buck_a_disable, ldoFault, regOcp, regUvp, regOvp, motorOcp, thermal_shutdown;
	logic waitrequest, ldoEn, pumpEn, reset_out_n, monitorOut, serialClk, serialData;
	logic latch_strobe;
	logic [1:0] converter_startup_select;
	logic [2:0] bridgeEnable, bridgePhase, convFault, buckEn, plusHigh, plusLow, minusHigh;
	logic [2:0] minusLow;
	logic [3:0] address;
	logic [31:0] writedata, readdata, r;
	int n_errors = 0;
	int comparisons = 0;
	int seed = 25781;
	int n;
	wire [5:0] st = {reset_out_n, pumpEn, ldoEn, buckEn};
	wire [11:0] sw = {plusHigh, plusLow, minusHigh, minusLow};
	driver_supervisor #(.PUMP_CYC(PUMP), .STEP_CYC(STEP), .PULSE_CYC(PULSE), .PORT_CYC(PORT),
		.DEGLITCH_CYC(2), .REV_CODE(REV), .DEV_CODE(DEV)) i_dut (.clk, .rst, .clkEn, .address,
		.read, .write, .writedata, .readdata, .waitrequest, .supplyLow, .system_clear_n, .sleep_n,
		.wake_request_n, .converter_startup_select, .buck_a_disable, .bridgeEnable, .bridgePhase,
		.serialClk, .serialData, .latch_strobe, .convFault, .ldoFault, .regOcp, .regUvp, .regOvp,
		.motorOcp, .thermal_shutdown, .buckEn, .ldoEn, .pumpEn, .reset_out_n, .monitorOut,
		.plusHigh, .plusLow, .minusHigh, .minusLow);
	host_serial_model host (.clk, .serialClk, .serialData, .latch_strobe);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic inrange(input int k, input int lo, input int hi);
		comparisons++;
		if (k < lo || k > hi) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h..%h", $time, k, lo, hi);
		end
	endtask
	task automatic waitlvl(input int b, input logic v, output int k);
		k = 0;
		while (st[b] !== v && k < 1000) begin
			@(posedge clk);
			k++;
		end
		if (k >= 1000) n_errors++;
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int k;
		k = 0;
		{address, writedata, read, write} <= {a, d, !wr, wr};
		do begin
			@(posedge clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 50);
		if (k >= 50) n_errors++;
		q = readdata;
		{read, write} <= 2'b00;
		@(posedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		cmp(q, e);
	endtask
	function automatic logic mon_exp(input logic [3:0] c);
		case (c)
			4'h4: return !regUvp;
			4'h5: return !regOvp;
			4'h8, 4'h9, 4'hA: return REV[c[1:0]];
			4'hB: return DEV[0];
			4'hC: return DEV[1];
			default: return 1'b1;
		endcase
	endfunction
	function automatic logic [11:0] br_exp(input logic [2:0] en, input logic [2:0] ph);
		return {en & ph, en & ~ph, en & ~ph, en & ph};
	endfunction
	task automatic test_done;
		if (n_errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		cyc(20000);
		n_errors++;
		test_done;
	end
	initial begin
		{rst, clkEn, system_clear_n, sleep_n, wake_request_n} = 5'h1F;
		{read, write, supplyLow, buck_a_disable, ldoFault, regOcp, regUvp, regOvp} = 8'h00;
		{motorOcp, thermal_shutdown, convFault, bridgeEnable, bridgePhase} = 11'h000;
		{address, writedata} = 36'h0_0000_0000;
		converter_startup_select = 2'h2;
		cyc(16);
		rst <= 1'b0;
		waitlvl(4, 1'b1, n);
		waitlvl(1, 1'b1, n);
		inrange(n, PUMP, 2 * PUMP);
		cmp({ldoEn, buckEn}, 4'hA);
		waitlvl(2, 1'b1, n);
		inrange(n, STEP, STEP + 2);
		waitlvl(5, 1'b1, n);
		inrange(n, PORT - 3 * PUMP, PORT);
		rd(4'h0, 32'h0000_0080);
		rd(4'h4, 32'h0000_0000);
		rd(4'h2, 32'h0000_0000);
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			{bridgeEnable, bridgePhase, sleep_n} <= {r[5:0], i != 3};
			cyc(6);
			cmp(sw, br_exp(bridgeEnable & {3{sleep_n}}, bridgePhase));
		end
		sleep_n <= 1'b1;
		for (int c = 0; c < 16; c++) begin
			r = $random(seed);
			{regUvp, regOvp} <= r[1:0];
			wr(4'h8, c);
			cyc(6);
			cmp(monitorOut, mon_exp(c[3:0]));
		end
		{regUvp, regOvp} <= 2'h0;
		wr(4'h4, 32'h0000_0800);
		cyc(6);
		cmp({pumpEn, buckEn}, 4'h0);
		wake_request_n <= 1'b0;
		cyc(6);
		wake_request_n <= 1'b1;
		rd(4'h4, 32'h0000_0000);
		cmp(buckEn, 3'h6);
		wr(4'h0, 32'h0000_2200);
		cyc(3);
		cmp({ldoEn, buckEn}, 4'h3);
		buck_a_disable <= 1'b1;
		cyc(6);
		cmp(buckEn, 3'h2);
		{buck_a_disable, sleep_n} <= 2'b00;
		cyc(6);
		host.send(16'h0004, 1'b1);
		regUvp <= 1'b1;
		cyc(6);
		cmp(monitorOut, 1'b0);
		{sleep_n, regUvp} <= 2'b10;
		rd(4'h8, 32'h0000_0004);
		{bridgeEnable, system_clear_n} <= 4'hE;
		cyc(1);
		system_clear_n <= 1'b1;
		cyc(10);
		cmp({reset_out_n, buckEn}, 4'hB);
		wr(4'h8, 32'h0000_0000);
		motorOcp <= 1'b1;
		waitlvl(5, 1'b0, n);
		motorOcp <= 1'b0;
		waitlvl(5, 1'b1, n);
		inrange(n, PULSE - 1, PULSE + 1);
		cmp({sw, ldoEn, buckEn}, 16'h0003);
		sleep_n <= 1'b0;
		cyc(6);
		sleep_n <= 1'b1;
		cyc(6);
		cmp(sw, br_exp(3'h7, bridgePhase));
		wr(4'h8, 32'h0000_2201);
		{thermal_shutdown, convFault} <= 4'hA;
		cyc(6);
		cmp(monitorOut, 1'b0);
		{thermal_shutdown, convFault} <= 4'h0;
		cyc(6);
		cmp({reset_out_n, pumpEn, buckEn, sw}, 17'h1_9000);
		sleep_n <= 1'b0;
		cyc(6);
		sleep_n <= 1'b1;
		cyc(6);
		cmp({buckEn, sw}, {3'h3, br_exp(3'h7, bridgePhase)});
		wr(4'h8, 32'h0000_8000);
		motorOcp <= 1'b1;
		cyc(8);
		{motorOcp, sleep_n} <= 2'b00;
		cyc(6);
		sleep_n <= 1'b1;
		cyc(6);
		cmp({reset_out_n, ldoEn, buckEn, sw}, 17'h0_0000);
		{converter_startup_select, system_clear_n} <= 3'h0;
		cyc(12);
		system_clear_n <= 1'b1;
		waitlvl(5, 1'b1, n);
		inrange(n, PORT, PORT + 12);
		cmp({ldoEn, buckEn}, 4'h0);
		rd(4'h8, 32'h0000_0000);
		rd(4'h0, 32'h0000_2380);
		sleep_n <= 1'b0;
		cyc(8);
		cmp(pumpEn, 1'b0);
		convFault <= 3'h4;
		cyc(6);
		{convFault, sleep_n} <= 4'h1;
		cyc(6);
		cmp({reset_out_n, pumpEn}, 2'h0);
		supplyLow <= 1'b1;
		cyc(8);
		cmp(reset_out_n, 1'b0);
		rd(4'hC, 32'h0000_0000);
		test_done;
	end
endmodule

// file: bench/host_serial_model.sv
// host model driving the serial configuration port
module host_serial_model (
	input wire clk,
	output logic serialClk = 1'b1,
	output logic serialData = 1'b0,
	output logic latch_strobe = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	task automatic hold4;
		repeat (4) @(posedge clk);
	endtask
	// word lsb first on falling clock, then strobe rise with ext-register choice on data
	task automatic send(input logic [15:0] word, input logic ext);
		for (int i = 0; i < 16; i++) begin
			{serialClk, serialData} <= {1'b1, word[i]};
			hold4;
			serialClk <= 1'b0;
			hold4;
		end
		{serialClk, serialData, latch_strobe} <= {1'b1, ext, 1'b0};
		hold4;
		latch_strobe <= 1'b1;
		hold4;
		serialData <= ~ext;
	endtask
endmodule

// file: hw/clear_deglitch.v
// stability filter for the system clear level
module clear_deglitch #(
	parameter LEN = 125
) (
	input wire clk,
	input wire rst,
	input wire clkEn,
	input wire levelIn,
	output reg levelOut
);
	reg [9:0] stableCnt_r;
	always @(posedge clk) begin
		if (rst) begin
			stableCnt_r <= 10'h000;
			levelOut <= 1'b1;
		end else if (clkEn) begin
			if (levelIn == levelOut) begin
				stableCnt_r <= 10'h000;
			end else if (stableCnt_r == LEN - 1) begin
				stableCnt_r <= 10'h000;
				levelOut <= levelIn;
			end else begin
				stableCnt_r <= stableCnt_r + 10'h001;
			end
		end
	end
endmodule

// file: hw/driver_supervisor.v
// driver supervisor: start-up order, fault policy, bridges, monitor, register slave
`include "supervisor_consts.vh"
module driver_supervisor #(
	parameter PUMP_CYC = `PUMP_CYC,
	parameter STEP_CYC = `STEP_CYC,
	parameter PULSE_CYC = `PULSE_CYC,
	parameter PORT_CYC = `PORT_CYC,
	parameter DEGLITCH_CYC = `DEGLITCH_CYC,
	// arbitrary value
	parameter [2:0] REV_CODE = 3'h5,
	// arbitrary value
	parameter [1:0] DEV_CODE = 2'h2
) (
	input wire clk,
	input wire rst,
	input wire clkEn,
	input wire [3:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	output reg [31:0] readdata,
	output reg waitrequest,
	input wire supplyLow,
	input wire system_clear_n,
	input wire sleep_n,
	input wire wake_request_n,
	input wire [1:0] converter_startup_select,
	input wire buck_a_disable,
	input wire [2:0] bridgeEnable,
	input wire [2:0] bridgePhase,
	input wire serialClk,
	input wire serialData,
	input wire latch_strobe,
	input wire [2:0] convFault,
	input wire ldoFault,
	input wire regOcp,
	input wire regUvp,
	input wire regOvp,
	input wire motorOcp,
	input wire thermal_shutdown,
	output reg [2:0] buckEn,
	output reg ldoEn,
	output reg pumpEn,
	output reg reset_out_n,
	output reg monitorOut,
	output reg [2:0] plusHigh,
	output reg [2:0] plusLow,
	output reg [2:0] minusHigh,
	output reg [2:0] minusLow
);
	localparam [`CNT_W-1:0] PUMP_L = PUMP_CYC[`CNT_W-1:0];
	localparam [`CNT_W-1:0] STEP_L = STEP_CYC[`CNT_W-1:0];
	localparam [`CNT_W-1:0] PULSE_L = PULSE_CYC[`CNT_W-1:0];
	localparam [`CNT_W-1:0] PORT_L = PORT_CYC[`CNT_W-1:0];
	localparam [`CNT_W-1:0] ONE = 25'h000_0001;
	localparam [`CNT_W-1:0] ZERO = 25'h000_0000;

	wire [24:0] pinsRaw;
	wire [24:0] pinsSync;
	wire vmLow;
	wire clearRawN;
	wire clearN;
	wire sleepSync;
	wire wakeN;
	wire [1:0] selSync;
	wire aDisable;
	wire [2:0] enSync;
	wire [2:0] phSync;
	wire sClk;
	wire sData;
	wire strobe;
	wire [2:0] cFault;
	wire lFault;
	wire ocpAny;
	wire uvpAny;
	wire ovpAny;
	wire motorF;
	wire thermF;

	assign pinsRaw = {thermal_shutdown, motorOcp, regOvp, regUvp, regOcp, ldoFault,
		convFault, latch_strobe, serialData, serialClk, bridgePhase, bridgeEnable,
		buck_a_disable, converter_startup_select, wake_request_n, sleep_n,
		system_clear_n, supplyLow};
	assign {thermF, motorF, ovpAny, uvpAny, ocpAny, lFault, cFault, strobe, sData, sClk,
		phSync, enSync, aDisable, selSync, wakeN, sleepSync, clearRawN, vmLow} = pinsSync;

	pin_sync #(
		.W(25),
		.INIT(25'h000_000E)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.clkEn(clkEn),
		.pinIn(pinsRaw),
		.syncOut(pinsSync)
	);

	clear_deglitch #(
		.LEN(DEGLITCH_CYC)
	) u_clear (
		.clk(clk),
		.rst(rst),
		.clkEn(clkEn),
		.levelIn(clearRawN),
		.levelOut(clearN)
	);

	reg [2:0] state_r;
	reg [1:0] flushCnt_r;
	reg [`CNT_W-1:0] stepCnt_r;
	reg [`CNT_W-1:0] porCnt_r;
	reg [`CNT_W-1:0] pulseCnt_r;
	reg released_r;
	reg [1:0] selCap_r;
	reg [15:0] bank0_r;
	reg [15:0] bank1_r;
	reg [15:0] ext_r;
	reg cfgWritten_r;
	reg [15:0] shift_r;
	reg sClkPrev_r;
	reg strobePrev_r;
	reg sleepPrev_r;
	reg motorTrip_r;
	reg thermTrip_r;
	reg [3:0] selTrip_r;
	reg shutAll_r;

	wire gclr = rst | vmLow | ~clearN;
	wire sleepEff = sleepSync | ~released_r;
	wire sleepRise = released_r & sleepSync & ~sleepPrev_r;
	wire motorPol = ext_r[`EXT_MOTOR_POL];
	wire [1:0] thermPol = {ext_r[`EXT_THERM_HI], ext_r[`EXT_THERM_LO]};
	wire thermSoft = thermPol[0] ^ thermPol[1];
	wire [3:0] selMask = ext_r[`EXT_MASK_LO+3:`EXT_MASK_LO];
	wire [3:0] regFault4 = {lFault, cFault[0], cFault[1], cFault[2]};
	wire deepSleep = bank1_r[`B1_DEEP];
	wire faultArm = (state_r >= `ST_PUMP);
	wire motorNew = faultArm & motorF & ~motorTrip_r;
	wire thermNew = faultArm & thermF & ~thermTrip_r;
	wire pulseTrig = (motorNew & ~motorPol) | (thermNew & thermPol == 2'h2);
	wire allOff = shutAll_r | (motorTrip_r & motorPol) | (thermTrip_r & ~thermSoft);
	wire motorsOff = motorTrip_r | thermTrip_r | allOff;
	wire sClkFall = sClkPrev_r & ~sClk;
	wire strobeRise = strobe & ~strobePrev_r & ~sleepEff;
	wire avWr = write & ~waitrequest;
	wire avRd = read & waitrequest;

	// start-up sequencer
	always @(posedge clk) begin
		if (gclr) begin
			state_r <= `ST_OFF;
			flushCnt_r <= 2'h0;
			stepCnt_r <= ZERO;
			porCnt_r <= ZERO;
			released_r <= 1'b0;
			selCap_r <= `SEL_GND;
		end else if (clkEn) begin
			if (!released_r && state_r != `ST_OFF) begin
				if (porCnt_r == PORT_L - ONE) begin
					released_r <= 1'b1;
				end
				porCnt_r <= porCnt_r + ONE;
			end
			case (state_r)
				`ST_OFF: begin
					// wait out the synchroniser flush before strap capture
					if (flushCnt_r == 2'h2) begin
						state_r <= `ST_CAPT;
					end else begin
						flushCnt_r <= flushCnt_r + 2'h1;
					end
				end
				`ST_CAPT: begin
					selCap_r <= selSync;
					stepCnt_r <= ZERO;
					state_r <= `ST_PUMP;
				end
				`ST_PUMP: begin
					if (stepCnt_r == PUMP_L - ONE) begin
						stepCnt_r <= ZERO;
						state_r <= `ST_FIRST;
					end else begin
						stepCnt_r <= stepCnt_r + ONE;
					end
				end
				`ST_FIRST: begin
					if (stepCnt_r == STEP_L - ONE) begin
						stepCnt_r <= ZERO;
						state_r <= `ST_SECOND;
					end else begin
						stepCnt_r <= stepCnt_r + ONE;
					end
				end
				`ST_SECOND: begin
					state_r <= `ST_SECOND;
				end
				default: begin
					state_r <= `ST_OFF;
				end
			endcase
		end
	end

	// configuration registers, serial port and register writes
	always @(posedge clk) begin
		if (gclr) begin
			bank0_r <= `BANK0_RST;
			bank1_r <= `BANK1_RST;
			ext_r <= `EXT_RST;
			cfgWritten_r <= 1'b0;
			shift_r <= 16'h0000;
			sClkPrev_r <= 1'b0;
			strobePrev_r <= 1'b0;
		end else if (clkEn) begin
			sClkPrev_r <= sClk;
			strobePrev_r <= strobe;
			if (sClkFall) begin
				shift_r <= {sData, shift_r[15:1]};
			end
			if (state_r == `ST_CAPT) begin
				bank0_r[`B0_BUCK_B] <= (selSync == `SEL_GND);
				bank0_r[`B0_BUCK_C] <= (selSync == `SEL_GND) | (selSync == `SEL_PULLDN);
				bank0_r[`B0_LDO] <= (selSync == `SEL_GND);
			end
			if (deepSleep && !wakeN) begin
				bank1_r[`B1_DEEP] <= 1'b0;
			end
			if (strobeRise) begin
				cfgWritten_r <= 1'b1;
				if (sData) begin
					ext_r <= shift_r;
				end else if (shift_r[`BANK_SEL]) begin
					bank1_r <= shift_r;
				end else begin
					bank0_r <= shift_r;
				end
			end else if (avWr) begin
				case (address)
					`OFS_BANK0: begin
						bank0_r <= writedata[15:0];
						cfgWritten_r <= 1'b1;
					end
					`OFS_BANK1: begin
						bank1_r <= writedata[15:0];
						cfgWritten_r <= 1'b1;
					end
					`OFS_EXT: begin
						ext_r <= writedata[15:0];
						cfgWritten_r <= 1'b1;
					end
					default: begin
						cfgWritten_r <= cfgWritten_r;
					end
				endcase
			end
		end
	end

	// fault latches and reset pulse timer
	always @(posedge clk) begin
		if (gclr) begin
			motorTrip_r <= 1'b0;
			thermTrip_r <= 1'b0;
			selTrip_r <= 4'h0;
			shutAll_r <= 1'b0;
			pulseCnt_r <= ZERO;
			sleepPrev_r <= 1'b1;
		end else if (clkEn) begin
			sleepPrev_r <= sleepSync;
			motorTrip_r <= (faultArm & motorF) | (motorTrip_r & ~(sleepRise & ~motorPol));
			thermTrip_r <= (faultArm & thermF) | (thermTrip_r & ~(sleepRise & thermSoft));
			selTrip_r <= ({4{faultArm}} & regFault4 & selMask) |
				(selTrip_r & ~{4{sleepRise}});
			shutAll_r <= shutAll_r | (faultArm & |(regFault4 & ~selMask));
			if (pulseTrig) begin
				pulseCnt_r <= PULSE_L - ONE;
			end else if (pulseCnt_r != ZERO) begin
				pulseCnt_r <= pulseCnt_r - ONE;
			end
		end
	end

	// converter, regulator and pump demand
	reg [2:0] convReq;
	reg [2:0] convOn;
	reg ldoReq;
	reg pumpReq;
	reg resetLowReq;
	reg monNxt;
	always @* begin
		convReq = 3'h0;
		if (cfgWritten_r) begin
			convReq = ~{bank0_r[`B0_BUCK_C], bank0_r[`B0_BUCK_B], bank0_r[`B0_BUCK_A]};
		end else begin
			convReq[1] = ~bank0_r[`B0_BUCK_B] & (state_r >= `ST_FIRST);
			convReq[2] = ~bank0_r[`B0_BUCK_C] & (state_r == `ST_SECOND);
			convReq[0] = ~bank0_r[`B0_BUCK_A] & (state_r >= `ST_FIRST);
		end
		convReq[0] = convReq[0] & ~aDisable;
		convOn = convReq & ~{selTrip_r[0], selTrip_r[1], selTrip_r[2]};
		if (allOff || deepSleep || state_r < `ST_PUMP) begin
			convOn = 3'h0;
		end
		ldoReq = cfgWritten_r ? ~bank0_r[`B0_LDO] : convOn[1];
		ldoReq = ldoReq & ~selTrip_r[3] & ~allOff & ~deepSleep;
		pumpReq = (|convOn) | (sleepEff & (~(motorTrip_r | thermTrip_r | shutAll_r) |
			(motorTrip_r & ~thermTrip_r & ~shutAll_r)));
		if ((thermTrip_r && !thermSoft) || deepSleep || state_r < `ST_PUMP) begin
			pumpReq = 1'b0;
		end
		resetLowReq = ~released_r | allOff | pulseTrig | (pulseCnt_r != ZERO);
		case (ext_r[`EXT_SEL_LO+3:`EXT_SEL_LO])
			`MON_BUCK_A: monNxt = ~cFault[0];
			`MON_BUCK_B: monNxt = ~cFault[1];
			`MON_BUCK_C: monNxt = ~cFault[2];
			`MON_REG_OCP: monNxt = ~ocpAny;
			`MON_UVP: monNxt = ~uvpAny;
			`MON_OVP: monNxt = ~ovpAny;
			`MON_MOTOR: monNxt = ~motorF;
			`MON_THERM: monNxt = ~thermF;
			`MON_REV0: monNxt = REV_CODE[0];
			`MON_REV1: monNxt = REV_CODE[1];
			`MON_REV2: monNxt = REV_CODE[2];
			`MON_DEV0: monNxt = DEV_CODE[0];
			`MON_DEV1: monNxt = DEV_CODE[1];
			`MON_LDO: monNxt = ~lFault;
			default: monNxt = 1'b1;
		endcase
	end

	always @(posedge clk) begin
		if (gclr) begin
			buckEn <= 3'h0;
			ldoEn <= 1'b0;
			pumpEn <= 1'b0;
			reset_out_n <= 1'b0;
			monitorOut <= 1'b1;
		end else if (clkEn) begin
			buckEn <= convOn;
			ldoEn <= ldoReq;
			pumpEn <= pumpReq;
			reset_out_n <= ~resetLowReq;
			monitorOut <= monNxt;
		end
	end

	// bridge switch decode
	genvar b;
	generate
		for (b = 0; b < 3; b = b + 1) begin : g_bridge
			wire drive = released_r & sleepSync & enSync[b] & ~motorsOff & ~deepSleep;
			always @(posedge clk) begin
				if (gclr) begin
					plusHigh[b] <= 1'b0;
					plusLow[b] <= 1'b0;
					minusHigh[b] <= 1'b0;
					minusLow[b] <= 1'b0;
				end else if (clkEn) begin
					plusHigh[b] <= drive & phSync[b];
					minusLow[b] <= drive & phSync[b];
					plusLow[b] <= drive & ~phSync[b];
					minusHigh[b] <= drive & ~phSync[b];
				end
			end
		end
	endgenerate

	// register slave, one wait state per access
	always @(posedge clk) begin
		if (rst) begin
			readdata <= 32'h0000_0000;
			waitrequest <= 1'b1;
		end else if (clkEn) begin
			waitrequest <= ~((read | write) & waitrequest);
			if (avRd) begin
				case (address)
					`OFS_BANK0: readdata <= {16'h0000, bank0_r};
					`OFS_BANK1: readdata <= {16'h0000, bank1_r};
					`OFS_EXT: readdata <= {16'h0000, ext_r};
					`OFS_STATUS: readdata <= {16'h0000, state_r, released_r, cfgWritten_r,
						deepSleep, motorTrip_r, thermTrip_r, shutAll_r, selTrip_r,
						selCap_r, pumpEn};
					default: readdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

// file: hw/pin_sync.v
// two-flop synchroniser for a bundle of pin inputs
module pin_sync #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input wire clk,
	input wire rst,
	input wire clkEn,
	input wire [W-1:0] pinIn,
	output wire [W-1:0] syncOut
);
	reg [W-1:0] stage1_r;
	reg [W-1:0] stage2_r;
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge clk) begin
				if (rst) begin
					stage1_r[i] <= INIT[i];
					stage2_r[i] <= INIT[i];
				end else if (clkEn) begin
					stage1_r[i] <= pinIn[i];
					stage2_r[i] <= stage1_r[i];
				end
			end
		end
	endgenerate
	assign syncOut = stage2_r;
endmodule

// file: hw/supervisor_consts.vh
// constants of the driver supervisor: offsets, fields, defaults, timing
`ifndef SUPERVISOR_CONSTS_VH
`define SUPERVISOR_CONSTS_VH

`define CLK_KHZ 50000
`define CLK_MHZ 50

`define PUMP_WAIT_MS 10
`define STEP_WAIT_MS 10
`define RESET_PULSE_MS 40
`define PORT_DELAY_MS 300
`define DEGLITCH_MIN_NS 2500

`define PUMP_CYC (`PUMP_WAIT_MS * `CLK_KHZ)
`define STEP_CYC (`STEP_WAIT_MS * `CLK_KHZ)
`define PULSE_CYC (`RESET_PULSE_MS * `CLK_KHZ)
`define PORT_CYC (`PORT_DELAY_MS * `CLK_KHZ)
`define DEGLITCH_CYC ((`DEGLITCH_MIN_NS * `CLK_MHZ + 999) / 1000)

`define OFS_BANK0 4'h0
`define OFS_BANK1 4'h4
`define OFS_EXT 4'h8
`define OFS_STATUS 4'hC

`define BANK0_RST 16'h0080
`define BANK1_RST 16'h0000
`define EXT_RST 16'h0000

`define B0_BUCK_A 7
`define B0_BUCK_B 8
`define B0_BUCK_C 9
`define B0_LDO 13
`define BANK_SEL 15
`define B1_DEEP 11
`define EXT_SEL_LO 0
`define EXT_MASK_LO 8
`define EXT_THERM_LO 13
`define EXT_THERM_HI 14
`define EXT_MOTOR_POL 15

`define SEL_GND 2'h0
`define SEL_PULLDN 2'h1

`define MON_BUCK_A 4'h0
`define MON_BUCK_B 4'h1
`define MON_BUCK_C 4'h2
`define MON_REG_OCP 4'h3
`define MON_UVP 4'h4
`define MON_OVP 4'h5
`define MON_MOTOR 4'h6
`define MON_THERM 4'h7
`define MON_REV0 4'h8
`define MON_REV1 4'h9
`define MON_REV2 4'hA
`define MON_DEV0 4'hB
`define MON_DEV1 4'hC
`define MON_LDO 4'hE

`define ST_OFF 3'h0
`define ST_CAPT 3'h1
`define ST_PUMP 3'h2
`define ST_FIRST 3'h3
`define ST_SECOND 3'h4

`define CNT_W 25

`endif
